// ---- design/lumr_addr_wake.v ----
// Always-on detector that watches the serial bus during deep sleep and
// pulses a wake request when a start is followed by the device address.
// Assumes synchronised bus levels on the same clock as its inputs.
`timescale 1ns/10ps
module lumr_addr_wake (
  input wire core_clk_i,
  input wire nrst_i,
  input wire sleep_i,
  input wire [6:0] dev_addr_i,
  input wire scl_i,
  input wire sda_i,
  output reg wake_o
);
  reg scl_d_reg;
  reg sda_d_reg;
  reg armed_reg;
  reg [2:0] cnt_reg;
  reg [5:0] sh_reg;
  wire start_det;
  wire scl_rise;
  assign start_det = scl_i & scl_d_reg & sda_d_reg & ~sda_i;
  assign scl_rise = scl_i & ~scl_d_reg;

  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      armed_reg <= 1'b0;
      cnt_reg <= 3'h0;
      sh_reg <= 6'h00;
      wake_o <= 1'b0;
    end else begin
      scl_d_reg <= scl_i;
      sda_d_reg <= sda_i;
      wake_o <= 1'b0;
      if (!sleep_i) begin
        armed_reg <= 1'b0;
      end else if (start_det) begin
        armed_reg <= 1'b1;
        cnt_reg <= 3'h0;
      end else if (armed_reg && scl_rise) begin
        sh_reg <= {sh_reg[4:0], sda_i};
        cnt_reg <= cnt_reg + 3'h1;
        if (cnt_reg == 3'h6) begin
          armed_reg <= 1'b0;
          wake_o <= ({sh_reg, sda_i} == dev_addr_i);
        end
      end
    end
  end
endmodule // lumr_addr_wake

// ---- design/lumr_map.vh ----
// Register offsets, field positions, reset values and codes of the luminance,
// temperature and power-down register bank.
// Assumes it is included by its bare name from the design files.
`ifndef LUMR_MAP_VH
`define LUMR_MAP_VH

// Serial bus device address; the value is arbitrary.
`define LUMR_DEV_ADDR 7'h3A

`define LUMR_OFS_PIX_VMAX 8'h11
`define LUMR_OFS_CATH_LVL 8'h12
`define LUMR_OFS_REF_CUR 8'h13
`define LUMR_OFS_DIM 8'h14
`define LUMR_OFS_TGAIN 8'h15
`define LUMR_OFS_TOFF 8'h16
`define LUMR_OFS_TUPD 8'h17
`define LUMR_OFS_TOUT 8'h18
`define LUMR_OFS_APD 8'h19
`define LUMR_OFS_SPD 8'h1A

`define LUMR_RST_PIX_VMAX 8'h0D
`define LUMR_RST_CATH_LVL 8'h51
`define LUMR_RST_REF_CUR 8'h01
`define LUMR_RST_DIM 7'h01
`define LUMR_RST_TGAIN 6'h28
`define LUMR_RST_TOFF 8'hD7
`define LUMR_RST_TUPD 8'hFF
`define LUMR_RST_TOUT 8'h00
`define LUMR_RST_APD 8'h00
`define LUMR_RST_SPD 8'h00
`define LUMR_RD_UNMAPPED 8'h00

`define LUMR_COARSE_HI 7
`define LUMR_COARSE_LO 5
`define LUMR_FINE_HI 4
`define LUMR_FINE_LO 0
`define LUMR_DIM_HI 6
`define LUMR_TGAIN_HI 5
`define LUMR_SPD_TOTAL 6
`define LUMR_APD_TEMP_SENSOR 1

// Coarse reference current factors in units of 1/32: 0, 0.5, 1.5, 2.5, 3.5.
`define LUMR_COARSE_F0 8'h00
`define LUMR_COARSE_F1 8'h10
`define LUMR_COARSE_F2 8'h30
`define LUMR_COARSE_F3 8'h50
`define LUMR_COARSE_F4 8'h70

`define LUMR_MODE_AUTO 2'b00
`define LUMR_MODE_AUTO_CLAMP 2'b01
`define LUMR_MODE_MANUAL 2'b10

`define LUMR_TEMP_SHIFT 5
`define LUMR_TEMP_BIAS 11'h100

`endif

// ---- design/lumr_regs.v ----
// Serially accessed register bank: luminance trims, temperature readout
// control and power-down controls, with a two-wire bus slave and wake-up.
// Assumes frame_start_i, cathode_supply_mode_i and temp_sense_raw_i come
// from on-chip logic on core_clk_i; scl_i and sda_i come from pins.
`timescale 1ns/10ps
`include "lumr_map.vh"
// Operation
// - Pixel max voltage trim, 8 bits, reset 0Dh, sets supply fraction.
// - Manual cathode level, reset 51h, drives inverter only in modes 01, 10.
// - Reference current: coarse bits 7-5 factors 0..3.5, fine bits 4-0 n/32.
// - Maximum luminance follows sum of coarse and fine factors.
// - Dimming bits 6-0 scale luminance in 1 percent steps, reset 01h.
// - Dimming applies only in automatic mode 00, ignored otherwise.
// - Six-bit gain divider, reset 28, scales temperature readout slope.
// - Eight-bit offset trim, reset D7, added to temperature readout.
// - Readout refreshes every N+1 frames; interval register resets to FF.
// - Readout is read-only and changes only at update instants.
// - Readout saturates at 0 and FF, never wraps.
// - Analog power-down bits 7..0 each switch one circuit off, reset 0.
// - System power-down bits 6,5,3,2,1,0 switch units off, reset 0.
// - Total power-down bit enters deep sleep, bus interface included.
// - In sleep, own bus address seen clears total power-down bit.
// - All registers keep their contents through deep sleep.
// - Mode codes: 00 automatic, 01 automatic with clamp, 10 manual.
module lumr_regs (
  input wire core_clk_i,
  input wire nrst_i,
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_n_o,
  input wire frame_start_i,
  input wire [1:0] cathode_supply_mode_i,
  input wire [7:0] temp_sense_raw_i,
  output reg [7:0] pixel_max_voltage_trim_o,
  output reg [7:0] cathode_level_o,
  output reg cathode_manual_o,
  output reg [7:0] ref_current_factor_o,
  output reg [14:0] lum_target_o,
  output reg [7:0] analog_powerdown_ctl_o,
  output reg [7:0] system_powerdown_ctl_o,
  output reg deep_sleep_o,
  output reg temp_update_o
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_ACKWAIT = 3'd2;
  localparam ST_ACK = 3'd3;
  localparam ST_WR = 3'd4;
  localparam ST_RD = 3'd5;
  localparam ST_RACK = 3'd6;
  localparam ST_RNEXT = 3'd7;

  reg [7:0] pix_vmax_reg;
  reg [7:0] cath_lvl_reg;
  reg [7:0] ref_cur_reg;
  reg [6:0] dim_reg;
  reg [5:0] tgain_reg;
  reg [7:0] toff_reg;
  reg [7:0] tupd_reg;
  reg [7:0] tout_reg;
  reg [7:0] apd_reg;
  reg [7:0] spd_reg;

  reg scl_m_reg;
  reg scl_s_reg;
  reg scl_d_reg;
  reg sda_m_reg;
  reg sda_s_reg;
  reg sda_d_reg;

  reg [2:0] state_reg;
  reg [2:0] bitcnt_reg;
  reg [7:0] sh_reg;
  reg [7:0] tx_reg;
  reg [7:0] ptr_reg;
  reg rw_reg;
  reg first_reg;
  reg wr_en_reg;
  reg [7:0] wr_addr_reg;
  reg [7:0] wr_data_reg;

  reg [7:0] frame_cnt_reg;
  reg upd_pend_reg;

  wire start_det;
  wire stop_det;
  wire scl_rise;
  wire scl_fall;
  wire [7:0] rx_byte;
  wire [7:0] rd_byte;
  wire [7:0] temp_value;
  wire wake;
  wire sleeping;
  wire sensor_on;

  // Read decode; anything outside the bank reads as zero.
  function [7:0] reg_read;
    input [7:0] a;
    begin
      case (a)
        `LUMR_OFS_PIX_VMAX: reg_read = pix_vmax_reg;
        `LUMR_OFS_CATH_LVL: reg_read = cath_lvl_reg;
        `LUMR_OFS_REF_CUR: reg_read = ref_cur_reg;
        `LUMR_OFS_DIM: reg_read = {1'b0, dim_reg};
        `LUMR_OFS_TGAIN: reg_read = {2'b00, tgain_reg};
        `LUMR_OFS_TOFF: reg_read = toff_reg;
        `LUMR_OFS_TUPD: reg_read = tupd_reg;
        `LUMR_OFS_TOUT: reg_read = tout_reg;
        `LUMR_OFS_APD: reg_read = apd_reg;
        `LUMR_OFS_SPD: reg_read = spd_reg;
        default: reg_read = `LUMR_RD_UNMAPPED;
      endcase
    end
  endfunction

  // Coarse codes 5 to 7 have no defined factor and give a zero coarse factor.
  function [7:0] coarse_factor;
    input [2:0] c;
    begin
      case (c)
        3'd0: coarse_factor = `LUMR_COARSE_F0;
        3'd1: coarse_factor = `LUMR_COARSE_F1;
        3'd2: coarse_factor = `LUMR_COARSE_F2;
        3'd3: coarse_factor = `LUMR_COARSE_F3;
        3'd4: coarse_factor = `LUMR_COARSE_F4;
        default: coarse_factor = `LUMR_COARSE_F0;
      endcase
    end
  endfunction

  assign start_det = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg;
  assign stop_det = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;
  assign scl_rise = scl_s_reg & ~scl_d_reg;
  assign scl_fall = ~scl_s_reg & scl_d_reg;
  assign rx_byte = {sh_reg[6:0], sda_s_reg};
  assign rd_byte = reg_read(ptr_reg);
  assign sleeping = spd_reg[`LUMR_SPD_TOTAL];
  assign sensor_on = ~apd_reg[`LUMR_APD_TEMP_SENSOR];

  lumr_addr_wake u_wake (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .sleep_i(sleeping),
    .dev_addr_i(`LUMR_DEV_ADDR),
    .scl_i(scl_s_reg),
    .sda_i(sda_s_reg),
    .wake_o(wake)
  );

  lumr_temp_calc u_temp (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .raw_i(temp_sense_raw_i),
    .gain_i(tgain_reg),
    .offset_i(toff_reg),
    .value_o(temp_value)
  );

  // Two-stage synchronisers, then one more stage for edge detection.
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_m_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_m_reg <= scl_i;
      scl_s_reg <= scl_m_reg;
      scl_d_reg <= scl_s_reg;
      sda_m_reg <= sda_i;
      sda_s_reg <= sda_m_reg;
      sda_d_reg <= sda_s_reg;
    end
  end

  // Bus slave: the first written byte sets the pointer, later bytes write
  // and reads auto-increment. Open-drain data: oe_n low pulls the line low.
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= ST_IDLE;
      bitcnt_reg <= 3'h0;
      sh_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      first_reg <= 1'b0;
      wr_en_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
      sda_o <= 1'b0;
      sda_oe_n_o <= 1'b1;
    end else begin
      wr_en_reg <= 1'b0;
      sda_o <= 1'b0;
      if (sleeping) begin
        state_reg <= ST_IDLE;
        sda_oe_n_o <= 1'b1;
      end else if (start_det) begin
        state_reg <= ST_ADDR;
        bitcnt_reg <= 3'h0;
        sda_oe_n_o <= 1'b1;
      end else if (stop_det) begin
        state_reg <= ST_IDLE;
        sda_oe_n_o <= 1'b1;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            sda_oe_n_o <= 1'b1;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              sh_reg <= rx_byte;
              bitcnt_reg <= bitcnt_reg + 3'h1;
              if (bitcnt_reg == 3'h7) begin
                if (rx_byte[7:1] == `LUMR_DEV_ADDR) begin
                  rw_reg <= rx_byte[0];
                  first_reg <= ~rx_byte[0];
                  state_reg <= ST_ACKWAIT;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end
            end
          end
          ST_ACKWAIT: begin
            if (scl_fall) begin
              sda_oe_n_o <= 1'b0;
              state_reg <= ST_ACK;
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bitcnt_reg <= 3'h0;
              if (rw_reg) begin
                tx_reg <= rd_byte;
                sda_oe_n_o <= rd_byte[7];
                state_reg <= ST_RD;
              end else begin
                sda_oe_n_o <= 1'b1;
                state_reg <= ST_WR;
              end
            end
          end
          ST_WR: begin
            if (scl_rise) begin
              sh_reg <= rx_byte;
              bitcnt_reg <= bitcnt_reg + 3'h1;
              if (bitcnt_reg == 3'h7) begin
                state_reg <= ST_ACKWAIT;
                first_reg <= 1'b0;
                if (first_reg) begin
                  ptr_reg <= rx_byte;
                end else begin
                  wr_en_reg <= 1'b1;
                  wr_addr_reg <= ptr_reg;
                  wr_data_reg <= rx_byte;
                  ptr_reg <= ptr_reg + 8'h01;
                end
              end
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              bitcnt_reg <= bitcnt_reg + 3'h1;
              if (bitcnt_reg == 3'h7) begin
                sda_oe_n_o <= 1'b1;
                state_reg <= ST_RACK;
              end else begin
                sda_oe_n_o <= tx_reg[6];
                tx_reg <= {tx_reg[6:0], 1'b0};
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              if (sda_s_reg) begin
                state_reg <= ST_IDLE;
              end else begin
                ptr_reg <= ptr_reg + 8'h01;
                state_reg <= ST_RNEXT;
              end
            end
          end
          ST_RNEXT: begin
            if (scl_fall) begin
              bitcnt_reg <= 3'h0;
              tx_reg <= rd_byte;
              sda_oe_n_o <= rd_byte[7];
              state_reg <= ST_RD;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
            sda_oe_n_o <= 1'b1;
          end
        endcase
      end
    end
  end

  // Register file. Only reset, bus writes and the wake clear touch it, so contents survive sleep.
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pix_vmax_reg <= `LUMR_RST_PIX_VMAX;
      cath_lvl_reg <= `LUMR_RST_CATH_LVL;
      ref_cur_reg <= `LUMR_RST_REF_CUR;
      dim_reg <= `LUMR_RST_DIM;
      tgain_reg <= `LUMR_RST_TGAIN;
      toff_reg <= `LUMR_RST_TOFF;
      tupd_reg <= `LUMR_RST_TUPD;
      apd_reg <= `LUMR_RST_APD;
      spd_reg <= `LUMR_RST_SPD;
    end else begin
      if (wr_en_reg) begin
        case (wr_addr_reg)
          `LUMR_OFS_PIX_VMAX: pix_vmax_reg <= wr_data_reg;
          `LUMR_OFS_CATH_LVL: cath_lvl_reg <= wr_data_reg;
          `LUMR_OFS_REF_CUR: ref_cur_reg <= wr_data_reg;
          `LUMR_OFS_DIM: dim_reg <= wr_data_reg[`LUMR_DIM_HI:0];
          `LUMR_OFS_TGAIN: tgain_reg <= wr_data_reg[`LUMR_TGAIN_HI:0];
          `LUMR_OFS_TOFF: toff_reg <= wr_data_reg;
          // Values below 02h are the host's fault and are stored as written.
          `LUMR_OFS_TUPD: tupd_reg <= wr_data_reg;
          `LUMR_OFS_APD: apd_reg <= wr_data_reg;
          `LUMR_OFS_SPD: spd_reg <= wr_data_reg;
          default: begin
          end
        endcase
      end
      // The slave is idle in sleep, so the wake clear never meets a write.
      if (wake) begin
        spd_reg[`LUMR_SPD_TOTAL] <= 1'b0;
      end
    end
  end

  // Frame counter: an update falls on every (N+1)th frame start. The new
  // readout is taken one cycle later so the calculator sees settled inputs.
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      frame_cnt_reg <= 8'h00;
      upd_pend_reg <= 1'b0;
      tout_reg <= `LUMR_RST_TOUT;
      temp_update_o <= 1'b0;
    end else begin
      upd_pend_reg <= 1'b0;
      temp_update_o <= 1'b0;
      if (frame_start_i && !sleeping) begin
        if (frame_cnt_reg == 8'h00) begin
          frame_cnt_reg <= tupd_reg;
          upd_pend_reg <= sensor_on;
        end else begin
          frame_cnt_reg <= frame_cnt_reg - 8'h01;
        end
      end
      if (upd_pend_reg) begin
        tout_reg <= temp_value;
        temp_update_o <= 1'b1;
      end
    end
  end

  // Registered analog controls derived from the bank.
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pixel_max_voltage_trim_o <= `LUMR_RST_PIX_VMAX;
      cathode_level_o <= 8'h00;
      cathode_manual_o <= 1'b0;
      ref_current_factor_o <= 8'h00;
      lum_target_o <= 15'h0000;
      analog_powerdown_ctl_o <= `LUMR_RST_APD;
      system_powerdown_ctl_o <= `LUMR_RST_SPD;
      deep_sleep_o <= 1'b0;
    end else begin
      pixel_max_voltage_trim_o <= pix_vmax_reg;
      ref_current_factor_o <= coarse_factor(ref_cur_reg[`LUMR_COARSE_HI:`LUMR_COARSE_LO])
        + {3'b000, ref_cur_reg[`LUMR_FINE_HI:`LUMR_FINE_LO]};
      if (cathode_supply_mode_i == `LUMR_MODE_AUTO) begin
        lum_target_o <= ref_current_factor_o * dim_reg;
      end else begin
        lum_target_o <= 15'h0000;
      end
      if ((cathode_supply_mode_i == `LUMR_MODE_AUTO_CLAMP) ||
          (cathode_supply_mode_i == `LUMR_MODE_MANUAL)) begin
        cathode_level_o <= cath_lvl_reg;
        cathode_manual_o <= 1'b1;
      end else begin
        cathode_level_o <= 8'h00;
        cathode_manual_o <= 1'b0;
      end
      analog_powerdown_ctl_o <= apd_reg;
      system_powerdown_ctl_o <= spd_reg;
      deep_sleep_o <= spd_reg[`LUMR_SPD_TOTAL];
    end
  end
endmodule // lumr_regs

// ---- design/lumr_temp_calc.v ----
// Scales the raw temperature sensor code by the gain divider, adds the
// offset trim and saturates the result into an 8-bit readout.
// Assumes the raw code is produced by on-chip logic on the same clock.
`timescale 1ns/10ps
`include "lumr_map.vh"
module lumr_temp_calc (
  input wire core_clk_i,
  input wire nrst_i,
  input wire [7:0] raw_i,
  input wire [5:0] gain_i,
  input wire [7:0] offset_i,
  output reg [7:0] value_o
);
  wire [13:0] prod;
  wire [8:0] scaled;
  wire [10:0] sum;
  assign prod = raw_i * gain_i;
  assign scaled = prod[13:`LUMR_TEMP_SHIFT];
  // Bit 10 acts as the sign; the sum never exceeds 766 so it cannot overflow.
  assign sum = {2'b00, scaled} + {3'b000, offset_i} - `LUMR_TEMP_BIAS;

  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      value_o <= `LUMR_RST_TOUT;
    end else if (sum[10]) begin
      value_o <= 8'h00;
    end else if (sum[9:8] != 2'b00) begin
      value_o <= 8'hFF;
    end else begin
      value_o <= sum[7:0];
    end
  end
endmodule // lumr_temp_calc

// ---- verif/lumr_host_mdl.sv ----
// Behavioural host controller for the two-wire register bus.
// Assumes the bench resolves the open-drain data line and feeds it to sda_i.
`timescale 1ns/10ps
`include "lumr_map.vh"
module lumr_host_mdl (
  input wire core_clk_i,
  input wire sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  // Each level is held at least four cycles, beyond the three sampling stages, so the synchroniser never misses an edge.
  task automatic bit_x(input logic b, output logic r);
    tick(4);
    sda_low_o = ~b;
    tick(4);
    scl_o = 1'b1;
    tick(4);
    r = sda_i;
    tick(4);
    scl_o = 1'b0;
  endtask
  task automatic start();
    tick(4);
    sda_low_o = 1'b0;
    tick(4);
    scl_o = 1'b1;
    tick(8);
    sda_low_o = 1'b1;
    tick(8);
    scl_o = 1'b0;
  endtask
  task automatic stop();
    tick(4);
    sda_low_o = 1'b1;
    tick(4);
    scl_o = 1'b1;
    tick(8);
    sda_low_o = 1'b0;
    tick(8);
  endtask
  task automatic byte_x(input logic [7:0] tx, input logic ab, output logic [7:0] rx,
      output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(tx[i], r);
      rx[i] = r;
    end
    bit_x(ab, ak);
  endtask
  task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] d, output logic ok);
    logic [7:0] rx;
    logic a0, a1, a2;
    start();
    byte_x({`LUMR_DEV_ADDR, 1'b0}, 1'b1, rx, a0);
    byte_x(ptr, 1'b1, rx, a1);
    byte_x(d, 1'b1, rx, a2);
    stop();
    ok = ~(a0 | a1 | a2);
  endtask
  task automatic rd_reg(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
    logic [7:0] rx;
    logic a0, a1, a2, a3;
    start();
    byte_x({`LUMR_DEV_ADDR, 1'b0}, 1'b1, rx, a0);
    byte_x(ptr, 1'b1, rx, a1);
    start();
    byte_x({`LUMR_DEV_ADDR, 1'b1}, 1'b1, rx, a2);
    byte_x(8'hFF, 1'b1, d, a3);
    stop();
    ok = ~(a0 | a1 | a2);
  endtask
endmodule // lumr_host_mdl

// ---- verif/lumr_regs_properties.sv ----
// Concurrent checks on the register bank ports, bound into lumr_regs.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/10ps
module lumr_regs_chk (
  input logic core_clk_i,
  input logic nrst_i,
  input logic sda_o,
  input logic sda_oe_n_o,
  input logic frame_start_i,
  input logic [1:0] cathode_supply_mode_i,
  input logic [7:0] cathode_level_o,
  input logic cathode_manual_o,
  input logic [7:0] ref_current_factor_o,
  input logic [14:0] lum_target_o,
  input logic [7:0] analog_powerdown_ctl_o,
  input logic [7:0] system_powerdown_ctl_o,
  input logic deep_sleep_o,
  input logic temp_update_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  sleep_mirror_a: assert property (deep_sleep_o == system_powerdown_ctl_o[6])
    else $error("sleep flag differs from power-down bit");
  sleep_silent_a: assert property (deep_sleep_o [*8] |-> sda_oe_n_o)
    else $error("data line driven while asleep");
  ack_low_a: assert property (!sda_oe_n_o |-> !sda_o)
    else $error("data line driven high");
  cath_manual_a: assert property (cathode_manual_o ==
      ($past(cathode_supply_mode_i) == 2'b01 || $past(cathode_supply_mode_i) == 2'b10))
    else $error("manual flag does not follow mode");
  cath_zero_a: assert property (!cathode_manual_o |-> cathode_level_o == 8'h00)
    else $error("cathode level outside manual modes");
  lum_off_a: assert property ((cathode_supply_mode_i != 2'b00) [*3] |-> lum_target_o == 15'h0000)
    else $error("dimming active outside automatic mode");
  factor_max_a: assert property (ref_current_factor_o <= 8'h8F)
    else $error("reference factor out of range");
  upd_pulse_a: assert property (temp_update_o |=> !temp_update_o)
    else $error("update pulse longer than one cycle");
  upd_cause_a: assert property (temp_update_o |-> $past(frame_start_i, 2))
    else $error("update without frame start");
  sensor_off_a: assert property (analog_powerdown_ctl_o[1] [*3] |-> !temp_update_o)
    else $error("update while sensor off");

  cover property ($rose(deep_sleep_o));
  cover property (temp_update_o);
  cover property (cathode_manual_o && cathode_level_o != 8'h00);
endmodule // lumr_regs_chk

bind lumr_regs lumr_regs_chk chk_u (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .sda_o(sda_o),
  .sda_oe_n_o(sda_oe_n_o), .frame_start_i(frame_start_i),
  .cathode_supply_mode_i(cathode_supply_mode_i), .cathode_level_o(cathode_level_o),
  .cathode_manual_o(cathode_manual_o), .ref_current_factor_o(ref_current_factor_o),
  .lum_target_o(lum_target_o), .analog_powerdown_ctl_o(analog_powerdown_ctl_o),
  .system_powerdown_ctl_o(system_powerdown_ctl_o), .deep_sleep_o(deep_sleep_o),
  .temp_update_o(temp_update_o));

// ---- verif/lumr_regs_tb.sv ----
// Self-checking bench for the register bank, driven through the host model.
// Assumes a pull-up on the data line and inputs changed at the falling edge.
`timescale 1ns/10ps
`include "lumr_map.vh"
module lumr_regs_tb;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic frame_start_i = 1'b0;
  logic [1:0] mode = 2'b00;
  logic [7:0] raw = 8'h00;
  logic scl, host_low, sda_o, sda_oe_n_o, cath_man, deep_sleep, temp_upd;
  logic [7:0] trim, cath_lvl, factor, apd, spd;
  logic [14:0] lum;
  wire sda_w;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  int upd_count = 0;

  assign sda_w = ~host_low & (sda_oe_n_o | sda_o);
  always #50 core_clk_i = ~core_clk_i;

  lumr_regs dut_u (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .frame_start_i(frame_start_i),
    .cathode_supply_mode_i(mode), .temp_sense_raw_i(raw), .pixel_max_voltage_trim_o(trim),
    .cathode_level_o(cath_lvl), .cathode_manual_o(cath_man), .ref_current_factor_o(factor),
    .lum_target_o(lum), .analog_powerdown_ctl_o(apd), .system_powerdown_ctl_o(spd),
    .deep_sleep_o(deep_sleep), .temp_update_o(temp_upd));
  lumr_host_mdl host_u (.core_clk_i(core_clk_i), .sda_i(sda_w), .scl_o(scl),
    .sda_low_o(host_low));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cyc++;
    if (temp_upd === 1'b1) upd_count++;
    if (cyc == 80000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic ok;
    host_u.wr_reg(p, d, ok);
    check(ok, 1'b1);
  endtask
  task automatic rd_chk(input logic [7:0] p, input logic [7:0] exp);
    logic ok;
    logic [7:0] d;
    host_u.rd_reg(p, d, ok);
    check(ok, 1'b1);
    check(d, exp);
  endtask
  task automatic frame();
    @(negedge core_clk_i) frame_start_i = 1'b1;
    @(negedge core_clk_i) frame_start_i = 1'b0;
    repeat (5) @(negedge core_clk_i);
  endtask

  task automatic t_reset();
    logic [7:0] exp [10] = '{8'h0D, 8'h51, 8'h01, 8'h01, 8'h28, 8'hD7, 8'hFF, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 10; i++) rd_chk(8'h11 + i[7:0], exp[i]);
    check(trim, 8'h0D);
    check(factor, 8'h01);
  endtask
  task automatic t_access();
    wr(`LUMR_OFS_TOUT, 8'h5A);
    rd_chk(`LUMR_OFS_TOUT, 8'h00);
    rd_chk(8'h1B, 8'h00);
    wr(`LUMR_OFS_PIX_VMAX, 8'hFF);
    check(trim, 8'hFF);
    wr(`LUMR_OFS_APD, 8'h5A);
    check(apd, 8'h5A);
    rd_chk(`LUMR_OFS_APD, 8'h5A);
    wr(`LUMR_OFS_APD, 8'h00);
    wr(`LUMR_OFS_SPD, 8'h2F);
    check(spd, 8'h2F);
    wr(`LUMR_OFS_SPD, 8'h00);
    wr(`LUMR_OFS_TGAIN, 8'hFF);
    rd_chk(`LUMR_OFS_TGAIN, 8'h3F);
  endtask
  task automatic t_factor();
    logic [7:0] cf [5] = '{8'h00, 8'h10, 8'h30, 8'h50, 8'h70};
    for (int c = 0; c < 5; c++) begin
      wr(`LUMR_OFS_REF_CUR, {c[2:0], 5'h1F});
      check(factor, cf[c] + 8'h1F);
    end
  endtask
  task automatic t_mode();
    wr(`LUMR_OFS_REF_CUR, 8'h30);
    wr(`LUMR_OFS_DIM, 8'h7F);
    wr(`LUMR_OFS_CATH_LVL, 8'hA0);
    for (int m = 0; m < 4; m++) begin
      @(negedge core_clk_i) mode = m[1:0];
      repeat (4) @(negedge core_clk_i);
      check(lum, (m == 0) ? 16'h0FE0 : 16'h0000);
      check(cath_man, (m == 1 || m == 2));
      check(cath_lvl, (m == 1 || m == 2) ? 8'hA0 : 8'h00);
    end
    @(negedge core_clk_i) mode = 2'b00;
    wr(`LUMR_OFS_DIM, 8'h64);
    check(lum, 16'h0C80);
  endtask
  // Readout is sat((raw * gain) >> 5 + offset - 256); offset stays at its reset value first.
  task automatic t_temp();
    wr(`LUMR_OFS_TUPD, 8'h02);
    wr(`LUMR_OFS_TGAIN, 8'h20);
    raw = 8'h80;
    frame();
    check(upd_count[15:0], 16'h0001);
    rd_chk(`LUMR_OFS_TOUT, 8'h57);
    raw = 8'hFF;
    wr(`LUMR_OFS_TGAIN, 8'h3F);
    frame();
    frame();
    check(upd_count[15:0], 16'h0001);
    rd_chk(`LUMR_OFS_TOUT, 8'h57);
    frame();
    check(upd_count[15:0], 16'h0002);
    rd_chk(`LUMR_OFS_TOUT, 8'hFF);
    raw = 8'h00;
    wr(`LUMR_OFS_TOFF, 8'h00);
    repeat (3) frame();
    check(upd_count[15:0], 16'h0003);
    rd_chk(`LUMR_OFS_TOUT, 8'h00);
    // With the sensor off the counter keeps running, so the first frame after it returns updates.
    wr(`LUMR_OFS_APD, 8'h02);
    repeat (2) frame();
    check(upd_count[15:0], 16'h0003);
    wr(`LUMR_OFS_APD, 8'h00);
    frame();
    check(upd_count[15:0], 16'h0004);
  endtask
  task automatic t_sleep();
    logic ok;
    wr(`LUMR_OFS_PIX_VMAX, 8'h3C);
    // Bring the frame counter to zero so a frame taken in sleep would update at once.
    repeat (2) frame();
    frame_start_i = 1'b0;
    host_u.wr_reg(`LUMR_OFS_SPD, 8'h40, ok);
    check(deep_sleep, 1'b1);
    frame();
    check(upd_count[15:0], 16'h0004);
    // This transaction wakes the device but is itself ignored.
    host_u.wr_reg(`LUMR_OFS_PIX_VMAX, 8'h99, ok);
    check(ok, 1'b0);
    check(deep_sleep, 1'b0);
    check(trim, 8'h3C);
    rd_chk(`LUMR_OFS_SPD, 8'h00);
    rd_chk(`LUMR_OFS_DIM, 8'h64);
    frame();
    check(upd_count[15:0], 16'h0005);
  endtask

  initial begin
    repeat (16) @(negedge core_clk_i);
    nrst_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    t_reset();
    t_access();
    t_factor();
    t_mode();
    t_temp();
    t_sleep();
    end_of_test();
  end
endmodule // lumr_regs_tb
